// [rtl/wcr_map.svh]
// register map, field positions, reset values and counts of the wake recovery registers
// assumes inclusion by wake_cdr_config_regs only; the bench files do not include it
`ifndef WCR_MAP_SVH
`define WCR_MAP_SVH
`define WCR_ADDR_OSC_CAL_LOW 7'h3B
`define WCR_ADDR_CTRL_ONE 7'h3C
`define WCR_ADDR_CLK_SEL 7'h3D
`define WCR_ADDR_UPPER 7'h3E
`define WCR_ADDR_LOWER 7'h3F
`define WCR_ADDR_RECOVERY_STAT 7'h4A
`define WCR_RST_OSC_CAL_LOW 8'h00
`define WCR_RST_CTRL_ONE 8'h04
`define WCR_RST_CLK_SEL 8'h00
`define WCR_RST_UPPER 8'hA8
`define WCR_RST_LOWER 8'h98
`define WCR_RST_STAT 8'h00
`define WCR_CTRL_ONE_MASK 8'h0D
`define WCR_CLK_SEL_MASK 8'h03
`define WCR_STAT_MASK 8'h07
`define WCR_BIT_ON 0
`define WCR_FILT_LSB 2
`define WCR_STAT_UPPER 0
`define WCR_STAT_LOWER 1
`define WCR_STAT_OVF 2
`define WCR_FRAME_BITS 5'h10
`define WCR_ADDR_BITS 5'h08
`define WCR_MAX_BITS 4'hA
`endif

// [rtl/wcr_pkg.sv]
// types used by the wake recovery register block; the bench files do not import them
// assumes nothing beyond a SystemVerilog compiler
package wcr_pkg;
  typedef enum logic [1:0] {
    WCR_TC8 = 2'b00,
    WCR_TC16 = 2'b01,
    WCR_TC32 = 2'b10,
    WCR_ADAPT = 2'b11
  } wcr_filt_t;
  typedef enum logic [1:0] {
    WCR_Q80 = 2'b00,
    WCR_Q40 = 2'b01,
    WCR_Q20 = 2'b10,
    WCR_Q10 = 2'b11
  } wcr_qclk_t;
endpackage

// [rtl/wake_cdr_config_regs.sv]
// recovery config and status registers behind a 16-bit spi slave, plus the bit-time tracker
// assumes spi pins, the can receive pin and the calibration byte come from outside clk
// How it works
// - low calibration byte is read only, zero after power-on or soft reset
// - control bit 0 switches recovery off at 0 and on at 1
// - filter field bits 3:2 gives time constant 8, 16 or 32
// - filter field 11 adapts constant to falling-edge spacing in bits
// - clock field bits 1:0 picks quanta clock 80, 40, 20 or 10 MHz
// - bit time above the upper limit is clamped to the upper limit
// - bit time below the lower limit is clamped to the lower limit
// - limits reset to A8 upper and 98 lower
// - first control register resets to 04: off, constant 16
// - a frame is 16 bits: 7 address bits, a mode bit, a data byte
// - data bits D0 to D7 travel in frame bits 8 to 15
// - status access with bit 7 low returns the byte unchanged
// - status access with bit 7 high returns the byte and clears it
// - status bits are only cleared by the controller, soft_reset or rst_n
// - reserved bits read as zero
`timescale 1ns/100ps
`include "wcr_map.svh"
module wake_cdr_config_regs
  import wcr_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic can_rx,
  input wire logic [7:0] osc_cal_low_in,
  input wire logic [7:0] bit_time_value,
  output logic recovery_on,
  output logic [1:0] quanta_clock_select,
  output logic [5:0] active_time_constant,
  output logic [7:0] recovered_bit_time
);

  // two-stage synchronisers; third stage feeds edge detection and the calibration byte agreement check
  logic [2:0] cs_q, sck_q, rx_q;
  logic [1:0] mosi_q;
  logic [7:0] cal_s1_q, cal_s2_q, cal_s3_q, cal_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_q <= 3'h7;
      sck_q <= 3'h0;
      rx_q <= 3'h7;
      mosi_q <= 2'h0;
      cal_s1_q <= 8'h00;
      cal_s2_q <= 8'h00;
      cal_s3_q <= 8'h00;
      cal_q <= `WCR_RST_OSC_CAL_LOW;
    end
    else
    begin
      cs_q <= {cs_q[1:0], spi_cs_n};
      sck_q <= {sck_q[1:0], spi_sck};
      rx_q <= {rx_q[1:0], can_rx};
      mosi_q <= {mosi_q[0], spi_mosi};
      cal_s1_q <= osc_cal_low_in;
      cal_s2_q <= cal_s1_q;
      cal_s3_q <= cal_s2_q;
      // a byte crossing as a bus may tear; take it only once two samples agree
      cal_q <= soft_reset ? `WCR_RST_OSC_CAL_LOW : (cal_s2_q == cal_s3_q) ? cal_s2_q : cal_q;
    end
  end

  wire cs_act = !cs_q[1];
  wire cs_rise = cs_q[1] && !cs_q[2];
  wire sck_rise = sck_q[1] && !sck_q[2];
  wire sck_fall = !sck_q[1] && sck_q[2];
  wire rx_fall = !rx_q[1] && rx_q[2];

  // control and status storage
  logic [7:0] ctrl_one_q, clk_sel_q, upper_q, lower_q, stat_q;
  logic [15:0] frame_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] tx_q;
  logic miso_q;

  // read mux, reserved bits masked to zero
  function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] c1,
    input logic [7:0] c2, input logic [7:0] up, input logic [7:0] lo,
    input logic [7:0] st, input logic [7:0] cal);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `WCR_ADDR_OSC_CAL_LOW: r = cal;
      `WCR_ADDR_CTRL_ONE: r = c1 & `WCR_CTRL_ONE_MASK;
      `WCR_ADDR_CLK_SEL: r = c2 & `WCR_CLK_SEL_MASK;
      `WCR_ADDR_UPPER: r = up;
      `WCR_ADDR_LOWER: r = lo;
      `WCR_ADDR_RECOVERY_STAT: r = st & `WCR_STAT_MASK;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // frame decode: bits 0..6 address, bit 7 mode, bits 8..15 data
  wire [6:0] fr_addr = frame_q[6:0];
  wire fr_mode = frame_q[7];
  wire [7:0] fr_data = frame_q[15:8];
  wire frame_done = cs_rise && (bit_cnt_q == `WCR_FRAME_BITS);
  wire do_write = frame_done && fr_mode;
  wire [7:0] rd_byte = read_reg(frame_q[14:8], ctrl_one_q, clk_sel_q, upper_q, lower_q,
    stat_q, cal_q);

  // spi shift: lsb first, sample on sck rise, drive on sck fall
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_q <= 16'h0000;
      bit_cnt_q <= 5'h00;
      tx_q <= 8'h00;
      miso_q <= 1'b0;
    end
    else if (!cs_act)
    begin
      bit_cnt_q <= 5'h00;
      miso_q <= 1'b0;
    end
    else if (sck_rise && bit_cnt_q != `WCR_FRAME_BITS)
    begin
      frame_q <= {mosi_q[1], frame_q[15:1]};
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
    else if (sck_fall)
    begin
      // after eight bits the address sits in frame_q[14:8], the mode bit in frame_q[15]
      if (bit_cnt_q == `WCR_ADDR_BITS)
      begin
        tx_q <= {1'b0, rd_byte[7:1]};
        miso_q <= rd_byte[0];
      end
      else if (bit_cnt_q > `WCR_ADDR_BITS)
      begin
        tx_q <= {1'b0, tx_q[7:1]};
        miso_q <= tx_q[0];
      end
    end
  end

  assign spi_miso_o = miso_q;
  assign spi_miso_oe = cs_act;

  // control register writes land only on a complete frame with mode bit set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_one_q <= `WCR_RST_CTRL_ONE;
      clk_sel_q <= `WCR_RST_CLK_SEL;
      upper_q <= `WCR_RST_UPPER;
      lower_q <= `WCR_RST_LOWER;
    end
    else if (soft_reset)
    begin
      ctrl_one_q <= `WCR_RST_CTRL_ONE;
      clk_sel_q <= `WCR_RST_CLK_SEL;
      upper_q <= `WCR_RST_UPPER;
      lower_q <= `WCR_RST_LOWER;
    end
    else if (do_write)
    begin
      if (fr_addr == `WCR_ADDR_CTRL_ONE)
        ctrl_one_q <= fr_data & `WCR_CTRL_ONE_MASK;
      if (fr_addr == `WCR_ADDR_CLK_SEL)
        clk_sel_q <= fr_data & `WCR_CLK_SEL_MASK;
      if (fr_addr == `WCR_ADDR_UPPER)
        upper_q <= fr_data;
      if (fr_addr == `WCR_ADDR_LOWER)
        lower_q <= fr_data;
    end
  end

  wire on_w = ctrl_one_q[`WCR_BIT_ON];
  wcr_filt_t filt_sel;
  wcr_qclk_t qsel;
  assign filt_sel = wcr_filt_t'(ctrl_one_q[`WCR_FILT_LSB +: 2]);
  assign qsel = wcr_qclk_t'(clk_sel_q[1:0]);

  // quanta tick: clk stands in for the fastest quanta clock, slower ones divide it
  logic [2:0] pre_q;
  logic [2:0] pre_mask;
  always_comb
  begin
    unique case (qsel)
      WCR_Q80: pre_mask = 3'h0;
      WCR_Q40: pre_mask = 3'h1;
      WCR_Q20: pre_mask = 3'h3;
      WCR_Q10: pre_mask = 3'h7;
    endcase
  end
  wire q_tick = (pre_q & pre_mask) == 3'h0;

  // spacing between falling edges in quanta, saturating
  logic [11:0] space_q;
  wire space_full = space_q == 12'hFFF;
  logic [15:0] acc_q; // 8.8 fixed-point filtered bit time

  // bit count of the last spacing: nearest multiple of the nominal, capped at 10
  function automatic logic [3:0] bits_of(input logic [11:0] sp, input logic [7:0] bt);
    logic [3:0] n;
    logic [12:0] lim;
    n = 4'h0;
    for (int k = 1; k <= 10; k++)
    begin
      lim = 13'(k) * 13'(bt) - 13'(bt >> 1);
      if ({1'b0, sp} >= lim)
        n = 4'(k);
    end
    return n;
  endfunction

  // reciprocal of the bit count, scaled by 256
  function automatic logic [8:0] recip(input logic [3:0] n);
    logic [8:0] r;
    r = 9'h000;
    for (int k = 1; k <= 10; k++)
      if (n == 4'(k))
        r = 9'(256 / k);
    return r;
  endfunction

  wire [3:0] nbits = bits_of(space_q, bit_time_value);
  wire edge_ok = rx_fall && on_w && !space_full && nbits != 4'h0 && nbits <= `WCR_MAX_BITS;
  logic [2:0] tc_shift;
  always_comb
  begin
    unique case (filt_sel)
      WCR_TC8: tc_shift = 3'h3;
      WCR_TC16: tc_shift = 3'h4;
      WCR_TC32: tc_shift = 3'h5;
      WCR_ADAPT: tc_shift = (nbits <= 4'h3) ? 3'h5 : (nbits <= 4'h8) ? 3'h4 : 3'h3;
    endcase
  end

  // error per bit against the filtered value, scaled down by the time constant
  wire signed [24:0] err_all = $signed({1'b0, space_q, 8'h00}) -
    $signed({5'h00, 20'(nbits) * 20'(acc_q)});
  wire signed [34:0] err_bit = err_all * $signed({1'b0, recip(nbits)});
  wire signed [26:0] delta = 27'(err_bit >>> 8) >>> tc_shift;
  wire signed [26:0] acc_new = $signed({11'h000, acc_q}) + delta;
  wire [7:0] raw_bt = acc_new[26] ? 8'h00 : (|acc_new[25:16]) ? 8'hFF : acc_new[15:8];
  wire hit_up = raw_bt > upper_q;
  wire hit_lo = raw_bt < lower_q;
  wire [15:0] acc_clamped = hit_up ? {upper_q, 8'h00} : hit_lo ? {lower_q, 8'h00} :
    acc_new[15:0];

  // tracker: seeded with the nominal while off, updated on each usable falling edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pre_q <= 3'h0;
      space_q <= 12'h000;
      acc_q <= 16'h0000;
    end
    else if (!on_w)
    begin
      pre_q <= 3'h0;
      space_q <= 12'h000;
      acc_q <= {bit_time_value, 8'h00};
    end
    else
    begin
      pre_q <= pre_q + 3'h1;
      if (rx_fall)
        space_q <= 12'h000;
      else if (q_tick && !space_full)
        space_q <= space_q + 12'h001;
      if (edge_ok)
        acc_q <= acc_clamped;
    end
  end

  // status flags: hardware set wins over a clearing frame; only that frame, soft_reset or rst_n clears them
  wire [7:0] stat_set = {5'h00, rx_fall && on_w && space_full, edge_ok && hit_lo,
    edge_ok && hit_up};
  wire stat_clr = do_write && fr_addr == `WCR_ADDR_RECOVERY_STAT;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_q <= `WCR_RST_STAT;
    else if (soft_reset)
      stat_q <= `WCR_RST_STAT;
    else
      stat_q <= ((stat_clr ? 8'h00 : stat_q) | stat_set) & `WCR_STAT_MASK;
  end

  // outputs to the wake receiver, all from flip-flops
  // in adapt mode the constant moves only on a usable edge, so it holds between edges
  wire tc_load = (filt_sel != WCR_ADAPT) || edge_ok;
  logic [5:0] tc_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tc_q <= 6'h10;
    else if (soft_reset)
      tc_q <= 6'h10;
    else if (tc_load)
      tc_q <= 6'(6'h01 << tc_shift);
  end
  assign active_time_constant = tc_q;
  assign recovery_on = on_w;
  assign quanta_clock_select = clk_sel_q[1:0];
  assign recovered_bit_time = acc_q[15:8];

endmodule

// [bench/wcr_mcu.sv]
// spi master model standing in for the microcontroller
// assumes clk at 100 MHz; sck runs 4 clk high, 4 clk low
`timescale 1ns/100ps
module wcr_mcu (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b1;
  end
  // one frame, lsb first; miso read while sck is high, where it is settled
  task automatic xfer(input logic [6:0] a, input logic m, input logic [7:0] d,
    output logic [7:0] q);
    logic [15:0] f;
    f = {d, m, a};
    cs_n <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      mosi <= f[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      @(negedge clk);
      if (i > 7)
        q[i-8] = miso;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    mosi <= ~mosi; // last bit inverted, no stale value
    repeat (8) @(posedge clk);
  endtask
endmodule

// [bench/wcr_chk_sva.sv]
// port assertions for the wake recovery register block
// assumes a bind into wake_cdr_config_regs; single clock domain
`timescale 1ns/100ps
module wcr_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe,
  input wire logic [7:0] bit_time_value,
  input wire logic recovery_on,
  input wire logic [1:0] quanta_clock_select,
  input wire logic [5:0] active_time_constant,
  input wire logic [7:0] recovered_bit_time
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] rises_q;
  // pin-level sck rises in this frame; the design lags by its synchronizer
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rises_q <= 5'h00;
    else if (spi_cs_n)
      rises_q <= 5'h00;
    else if ($rose(spi_sck) && rises_q != 5'h1F)
      rises_q <= rises_q + 5'h01;
  property p_oe_idle;
    spi_cs_n [*4] |-> !spi_miso_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("miso driven while deselected");
  property p_oe_sel;
    !spi_cs_n [*4] |-> spi_miso_oe;
  endproperty
  a_oe_sel: assert property (p_oe_sel)
    else $error("miso not driven while selected");
  property p_miso_low;
    rises_q >= 5'h02 && rises_q <= 5'h06 |-> !spi_miso_o;
  endproperty
  a_miso_low: assert property (p_miso_low)
    else $error("miso high in address half");
  property p_off_nominal;
    (!recovery_on && $stable(bit_time_value)) [*2] |=>
      recovered_bit_time == $past(bit_time_value);
  endproperty
  a_off_nominal: assert property (p_off_nominal)
    else $error("bit time not nominal while off");
  property p_tc_legal;
    active_time_constant inside {6'h08, 6'h10, 6'h20};
  endproperty
  a_tc_legal: assert property (p_tc_legal)
    else $error("time constant out of set");
  property p_on_change;
    $changed(recovery_on) && !$past(soft_reset) |-> spi_cs_n && $past(spi_cs_n, 3);
  endproperty
  a_on_change: assert property (p_on_change)
    else $error("enable moved outside a frame end");
  property p_sel_change;
    $changed(quanta_clock_select) && !$past(soft_reset) |-> spi_cs_n && $past(spi_cs_n, 3);
  endproperty
  a_sel_change: assert property (p_sel_change)
    else $error("clock select moved outside a frame end");
  property p_soft;
    soft_reset |=> !recovery_on && quanta_clock_select == 2'b00 && active_time_constant == 6'h10;
  endproperty
  a_soft: assert property (p_soft)
    else $error("soft reset values wrong");
  c_soft: cover property (soft_reset);
  c_on: cover property ($rose(recovery_on));
  c_clamp: cover property (recovery_on && recovered_bit_time == 8'hA8);
endmodule

// [bench/test_wake_cdr_config_regs.sv]
// self-checking bench for the wake recovery register block
// assumes wcr_mcu as spi master and wcr_chk bound at the foot
`timescale 1ns/100ps
module test_wake_cdr_config_regs;
  logic clk, rst_n, soft_reset, can_rx, cs_n, sck, mosi, miso_o, miso_oe, on;
  logic [1:0] qsel;
  logic [5:0] tc;
  logic [7:0] cal, btv, rbt, q;
  wire miso;
  int num_errors, n_compared;
  logic [6:0] adr [5] = '{7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F};
  logic [7:0] rv [5] = '{8'h00, 8'h04, 8'h00, 8'hA8, 8'h98};
  // undriven miso floats; the master samples it only while selected
  assign miso = miso_oe ? miso_o : 1'bz;
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  wcr_mcu mcu (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi), .miso(miso));
  wake_cdr_config_regs dut (.clk(clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .spi_miso_o(miso_o),
    .spi_miso_oe(miso_oe), .can_rx(can_rx), .osc_cal_low_in(cal),
    .bit_time_value(btv), .recovery_on(on), .quanta_clock_select(qsel),
    .active_time_constant(tc), .recovered_bit_time(rbt));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [6:0] a);
    mcu.xfer(a, 1'b0, 8'h00, q);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    mcu.xfer(a, 1'b1, d, q);
  endtask
  task automatic rst_vals;
    for (int i = 0; i < 5; i++)
    begin
      rd(adr[i]);
      chk(q, rv[i]);
    end
  endtask
  // falling edge every p clk; low part short so spacing alone sets the bit time
  task automatic edges(input int p, input int n);
    repeat (n)
    begin
      can_rx <= 1'b0;
      repeat (20) @(posedge clk);
      can_rx <= 1'b1;
      repeat (p - 20) @(posedge clk);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #500000;
    num_errors++;
    end_of_test;
  end
  initial
  begin
    rst_n = 1'b0;
    soft_reset = 1'b0;
    can_rx = 1'b1;
    cal = 8'h00;
    btv = 8'hA0;
    num_errors = 0;
    n_compared = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({2'b00, tc}, 8'h10);
    rst_vals;
    rd(7'h10);
    chk(q, 8'h00);
    wr(7'h3C, 8'hFF);
    rd(7'h3C);
    chk(q, 8'h0D);
    chk({7'h00, on}, 8'h01);
    for (int f = 0; f < 3; f++)
    begin
      wr(7'h3C, 8'h01 | 8'(f << 2));
      chk({2'b00, tc}, 8'h08 << f);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr(7'h3D, 8'hFC | 8'(s));
      rd(7'h3D);
      chk(q, 8'(s));
      chk({6'h00, qsel}, 8'(s));
    end
    cal <= 8'h5A;
    wr(7'h3B, 8'hFF);
    rd(7'h3B);
    chk(q, 8'h5A);
    wr(7'h3E, 8'hB0);
    wr(7'h3F, 8'h90);
    rd(7'h3E);
    chk(q, 8'hB0);
    rd(7'h3F);
    chk(q, 8'h90);
    cal <= 8'h00;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    repeat (4) @(posedge clk);
    rst_vals;
    // fastest quanta, constant 8; long spacing drives the value over the top
    wr(7'h3C, 8'h01);
    edges(224, 10);
    chk(rbt, 8'hA8);
    rd(7'h4A);
    chk(q & 8'h03, 8'h01);
    rd(7'h4A);
    chk(q & 8'h03, 8'h01);
    mcu.xfer(7'h4A, 1'b1, 8'h00, q);
    chk(q & 8'h03, 8'h01);
    rd(7'h4A);
    chk(q & 8'h03, 8'h00);
    edges(96, 10);
    chk(rbt, 8'h98);
    rd(7'h4A);
    chk(q & 8'h02, 8'h02);
    // adapt: two-bit spacing gives 32, nine bits 8, five bits 16
    wr(7'h3C, 8'h0D);
    edges(320, 3);
    chk({2'b00, tc}, 8'h20);
    edges(1440, 3);
    chk({2'b00, tc}, 8'h08);
    edges(800, 3);
    chk({2'b00, tc}, 8'h10);
    // half-rate quanta: 448 clk is one long bit here, three short ones at full rate
    wr(7'h3D, 8'h01);
    edges(448, 10);
    chk(rbt, 8'hA8);
    end_of_test;
  end
endmodule
bind wake_cdr_config_regs wcr_chk u_chk (.clk(clk), .rst_n(rst_n),
  .soft_reset(soft_reset), .spi_cs_n(spi_cs_n), .spi_sck(spi_sck),
  .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe), .bit_time_value(bit_time_value),
  .recovery_on(recovery_on), .quanta_clock_select(quanta_clock_select),
  .active_time_constant(active_time_constant), .recovered_bit_time(recovered_bit_time));
